// ==== rtl/ulfc_defines.svh ====
// Purpose: Register offsets, reset values and timing counts of the line format block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Field layouts live in the package as packed structs.
`ifndef ULFC_DEFINES_SVH
`define ULFC_DEFINES_SVH

`define ULFC_ADDR_W       8
`define ULFC_OFF_LFC      8'h00
`define ULFC_OFF_DATA     8'h04
`define ULFC_OFF_STAT     8'h08
`define ULFC_OFF_ISR      8'h0C
`define ULFC_OFF_IMR      8'h10

`define ULFC_LFC_RESET    8'h00
`define ULFC_EFR_RESET    8'h00
`define ULFC_DIV_RESET    16'h0364
`define ULFC_IRQ_W        4
`define ULFC_IRQ_TXDONE   0
`define ULFC_IRQ_RXDONE   1
`define ULFC_IRQ_PERR     2
`define ULFC_IRQ_FERR     3

`define ULFC_HALF_LAST    3'h1
`define ULFC_STOP_H_ONE   3'h2
`define ULFC_STOP_H_HALF  3'h3
`define ULFC_STOP_H_TWO   3'h4
`define ULFC_LEN_FIVE     2'h0

`endif

// ==== rtl/ulfc_pkg.sv ====
// Purpose: Types shared by the line format block.
// Assumes: Nothing beyond the defines header.
// Notes:   Format struct field order matches the register bit order, bit 7 first.
package ulfc_pkg;

   typedef struct packed {
      logic       div_open;
      logic       brk;
      logic       stick;
      logic       even;
      logic       par_en;
      logic       stop_long;
      logic [1:0] len;
   } ulfc_format_t;

   typedef struct packed {
      logic tx_done;
      logic rx_done;
      logic perr;
      logic ferr;
   } ulfc_event_t;

   typedef enum logic [2:0] {
      ULFC_IDLE,
      ULFC_START,
      ULFC_DATA,
      ULFC_PARITY,
      ULFC_STOP
   } ulfc_state_t;

endpackage

// ==== rtl/ulfc_line_format.sv ====
// Purpose: Character framing and checking for one serial channel, set by the
//          line format register, with an APB register slave and an interrupt.
// Assumes: Single clock pclk at 200 MHz; serial input is asynchronous.
// Notes:   The divisor counts pclk cycles per half bit time, minus one.
`timescale 1ns/1ps
`include "ulfc_defines.svh"

// Summary of operation
// - Format bit 7 set swaps data/status offsets to divisor and enhanced registers.
// - Format bit 6 set holds the serial output low until cleared.
// - Format bit 3 set appends a parity bit after the data bits.
// - Bit 5 clear: bit 4 zero gives odd parity, one gives even.
// - Bit 5 set: parity is constant, one if bit 4 zero, else zero.
// - Bit 3 clear: no parity bit, bits 4 and 5 ignored.
// - Stop is one bit, or with bit 2 set 1.5 (5-bit) or 2.
// - Bits 1:0 select 5, 6, 7 or 8 data bits both ways.
// - Reset clears the whole format register.
// - Receiver checks parity against its own format and flags mismatches.
module ulfc_line_format
   import ulfc_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     ce,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`ULFC_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     rx_in,
   output logic                          tx_out,
   output logic                          irq
);

   ulfc_format_t          lfc;
   ulfc_format_t          next_lfc;
   logic [15:0]           divisor;
   logic [15:0]           next_divisor;
   logic [7:0]            efr;
   logic [7:0]            next_efr;
   logic [`ULFC_IRQ_W-1:0] isr;
   logic [`ULFC_IRQ_W-1:0] next_isr;
   logic [`ULFC_IRQ_W-1:0] imr;
   logic [`ULFC_IRQ_W-1:0] next_imr;
   logic [7:0]            rx_hold;
   logic [7:0]            next_rx_hold;
   logic                  rx_valid;
   logic                  next_rx_valid;
   logic                  perr_seen;
   logic                  next_perr_seen;
   logic                  ferr_seen;
   logic                  next_ferr_seen;
   logic [31:0]           next_prdata;
   logic                  rx_meta;
   logic                  rx_sync;

   ulfc_event_t           ev;
   logic                  tx_done_ev;
   logic                  rx_done_ev;
   logic                  rx_perr_ev;
   logic                  rx_ferr_ev;
   logic                  wr_acc;
   logic                  rd_acc;
   logic                  setup;
   logic                  mapped;
   logic                  tx_start;

   ulfc_state_t           tx_state;
   ulfc_state_t           next_tx_state;
   ulfc_format_t          tx_fmt;
   ulfc_format_t          next_tx_fmt;
   logic [15:0]           tx_cnt;
   logic [15:0]           next_tx_cnt;
   logic [2:0]            tx_half;
   logic [2:0]            next_tx_half;
   logic [2:0]            tx_idx;
   logic [2:0]            next_tx_idx;
   logic [7:0]            tx_data;
   logic [7:0]            next_tx_data;
   logic                  tx_par;
   logic                  next_tx_par;
   logic                  tx_line;
   logic                  next_tx_line;

   ulfc_state_t           rx_state;
   ulfc_state_t           next_rx_state;
   ulfc_format_t          rx_fmt;
   ulfc_format_t          next_rx_fmt;
   logic [15:0]           rx_cnt;
   logic [15:0]           next_rx_cnt;
   logic [2:0]            rx_half;
   logic [2:0]            next_rx_half;
   logic [2:0]            rx_idx;
   logic [2:0]            next_rx_idx;
   logic [7:0]            rx_data;
   logic [7:0]            next_rx_data;
   logic                  rx_perr;
   logic                  next_rx_perr;

   // Index of the last data bit: 4 plus the length code gives 5 to 8 bits.
   function automatic logic [2:0] last_bit(input ulfc_format_t f);
      return {1'b1, f.len};
   endfunction

   // Parity bit for the data bits in use under format f.
   function automatic logic parity_of(input logic [7:0] d, input ulfc_format_t f);
      logic [7:0] m;
      logic       x;
      m = d & (8'hFF >> (3'h7 - last_bit(f)));
      x = ^m;
      if (f.stick) begin
         return ~f.even;
      end
      return f.even ? x : ~x;
   endfunction

   function automatic logic [2:0] stop_halves(input ulfc_format_t f);
      if (!f.stop_long) begin
         return `ULFC_STOP_H_ONE;
      end
      return (f.len == `ULFC_LEN_FIVE) ? `ULFC_STOP_H_HALF : `ULFC_STOP_H_TWO;
   endfunction

   // Serial input synchroniser; only rx_sync is read by logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else if (ce) begin
         rx_meta <= rx_in;
         rx_sync <= rx_meta;
      end
   end

   // Zero-wait slave: every access phase completes in one cycle.
   assign pready = 1'b1;
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign mapped = (paddr == `ULFC_OFF_LFC) || (paddr == `ULFC_OFF_DATA) ||
                   (paddr == `ULFC_OFF_STAT) || (paddr == `ULFC_OFF_ISR) ||
                   (paddr == `ULFC_OFF_IMR);
   assign pslverr = psel && penable && !mapped;
   assign tx_start = wr_acc && !lfc.div_open && (paddr == `ULFC_OFF_DATA) &&
                     (tx_state == ULFC_IDLE);
   assign irq = |(isr & imr);
   // Each framer drives its own event bits, so ev has a single driver.
   assign ev = {tx_done_ev, rx_done_ev, rx_perr_ev, rx_ferr_ev};
   assign tx_out = lfc.brk ? 1'b0 : tx_line;

   always_comb begin
      next_lfc       = lfc;
      next_divisor   = divisor;
      next_efr       = efr;
      next_imr       = imr;
      next_isr       = isr;
      next_rx_hold   = rx_hold;
      next_rx_valid  = rx_valid;
      next_perr_seen = perr_seen;
      next_ferr_seen = ferr_seen;
      next_prdata    = prdata;
      if (setup && !pwrite) begin
         next_prdata = 32'h0000_0000;
         case (paddr)
            `ULFC_OFF_LFC: next_prdata[7:0] = lfc;
            `ULFC_OFF_DATA: begin
               if (lfc.div_open) next_prdata[15:0] = divisor;
               else next_prdata[7:0] = rx_hold;
            end
            `ULFC_OFF_STAT: begin
               if (lfc.div_open) next_prdata[7:0] = efr;
               else next_prdata[3:0] = {ferr_seen, perr_seen, rx_valid,
                                        tx_state != ULFC_IDLE};
            end
            `ULFC_OFF_ISR: next_prdata[`ULFC_IRQ_W-1:0] = isr;
            `ULFC_OFF_IMR: next_prdata[`ULFC_IRQ_W-1:0] = imr;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            `ULFC_OFF_LFC: next_lfc = ulfc_format_t'(pwdata[7:0]);
            `ULFC_OFF_DATA: if (lfc.div_open) next_divisor = pwdata[15:0];
            `ULFC_OFF_STAT: if (lfc.div_open) next_efr = pwdata[7:0];
            `ULFC_OFF_IMR: next_imr = pwdata[`ULFC_IRQ_W-1:0];
            default: next_imr = imr;
         endcase
      end
      // Only the bits that the read reported are cleared, so an event that lands
      // on the setup edge, after the read data was taken, is not lost.
      if (rd_acc && (paddr == `ULFC_OFF_ISR)) begin
         next_isr = isr & ~prdata[`ULFC_IRQ_W-1:0];
      end
      if (rd_acc && !lfc.div_open && (paddr == `ULFC_OFF_DATA)) begin
         next_rx_valid = 1'b0;
      end
      // Hardware events are applied last so that a set beats a clear.
      next_isr = next_isr | {ev.ferr, ev.perr, ev.rx_done, ev.tx_done};
      if (ev.rx_done) begin
         next_rx_hold   = rx_data;
         next_rx_valid  = 1'b1;
         next_perr_seen = ev.perr;
         next_ferr_seen = ev.ferr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfc       <= ulfc_format_t'(`ULFC_LFC_RESET);
         divisor   <= `ULFC_DIV_RESET;
         efr       <= `ULFC_EFR_RESET;
         isr       <= '0;
         imr       <= '0;
         rx_hold   <= 8'h00;
         rx_valid  <= 1'b0;
         perr_seen <= 1'b0;
         ferr_seen <= 1'b0;
         prdata    <= 32'h0000_0000;
      end else if (ce) begin
         lfc       <= next_lfc;
         divisor   <= next_divisor;
         efr       <= next_efr;
         isr       <= next_isr;
         imr       <= next_imr;
         rx_hold   <= next_rx_hold;
         rx_valid  <= next_rx_valid;
         perr_seen <= next_perr_seen;
         ferr_seen <= next_ferr_seen;
         prdata    <= next_prdata;
      end
   end

   // Transmit framer: counts half-bit ticks, one phase per state.
   always_comb begin
      next_tx_state = tx_state;
      next_tx_fmt   = tx_fmt;
      next_tx_cnt   = tx_cnt;
      next_tx_half  = tx_half;
      next_tx_idx   = tx_idx;
      next_tx_data  = tx_data;
      next_tx_par   = tx_par;
      next_tx_line  = tx_line;
      tx_done_ev    = 1'b0;
      if (tx_state != ULFC_IDLE) begin
         next_tx_cnt = (tx_cnt == divisor) ? 16'h0000 : 16'(tx_cnt + 16'h0001);
      end
      case (tx_state)
         ULFC_IDLE: begin
            next_tx_line = 1'b1;
            if (tx_start) begin
               next_tx_fmt   = lfc;
               next_tx_data  = pwdata[7:0];
               next_tx_par   = parity_of(pwdata[7:0], lfc);
               next_tx_cnt   = 16'h0000;
               next_tx_half  = 3'h0;
               next_tx_line  = 1'b0;
               next_tx_state = ULFC_START;
            end
         end
         ULFC_START: begin
            if (tx_cnt == divisor) begin
               next_tx_half = 3'(tx_half + 3'h1);
               if (tx_half == `ULFC_HALF_LAST) begin
                  next_tx_half  = 3'h0;
                  next_tx_idx   = 3'h0;
                  next_tx_line  = tx_data[0];
                  next_tx_state = ULFC_DATA;
               end
            end
         end
         ULFC_DATA: begin
            if (tx_cnt == divisor) begin
               next_tx_half = 3'(tx_half + 3'h1);
               if (tx_half == `ULFC_HALF_LAST) begin
                  next_tx_half = 3'h0;
                  if (tx_idx == last_bit(tx_fmt)) begin
                     if (tx_fmt.par_en) begin
                        next_tx_line  = tx_par;
                        next_tx_state = ULFC_PARITY;
                     end else begin
                        next_tx_line  = 1'b1;
                        next_tx_state = ULFC_STOP;
                     end
                  end else begin
                     next_tx_idx  = 3'(tx_idx + 3'h1);
                     next_tx_line = tx_data[3'(tx_idx + 3'h1)];
                  end
               end
            end
         end
         ULFC_PARITY: begin
            if (tx_cnt == divisor) begin
               next_tx_half = 3'(tx_half + 3'h1);
               if (tx_half == `ULFC_HALF_LAST) begin
                  next_tx_half  = 3'h0;
                  next_tx_line  = 1'b1;
                  next_tx_state = ULFC_STOP;
               end
            end
         end
         ULFC_STOP: begin
            if (tx_cnt == divisor) begin
               next_tx_half = 3'(tx_half + 3'h1);
               if (tx_half == 3'(stop_halves(tx_fmt) - 3'h1)) begin
                  tx_done_ev    = 1'b1;
                  next_tx_state = ULFC_IDLE;
               end
            end
         end
         default: next_tx_state = ULFC_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= ULFC_IDLE;
         tx_fmt   <= ulfc_format_t'(`ULFC_LFC_RESET);
         tx_cnt   <= 16'h0000;
         tx_half  <= 3'h0;
         tx_idx   <= 3'h0;
         tx_data  <= 8'h00;
         tx_par   <= 1'b0;
         tx_line  <= 1'b1;
      end else if (ce) begin
         tx_state <= next_tx_state;
         tx_fmt   <= next_tx_fmt;
         tx_cnt   <= next_tx_cnt;
         tx_half  <= next_tx_half;
         tx_idx   <= next_tx_idx;
         tx_data  <= next_tx_data;
         tx_par   <= next_tx_par;
         tx_line  <= next_tx_line;
      end
   end

   // Receive checker: samples each bit at its middle, one half after the edge.
   always_comb begin
      next_rx_state = rx_state;
      next_rx_fmt   = rx_fmt;
      next_rx_cnt   = 16'h0000;
      next_rx_half  = rx_half;
      next_rx_idx   = rx_idx;
      next_rx_data  = rx_data;
      next_rx_perr  = rx_perr;
      rx_done_ev    = 1'b0;
      rx_perr_ev    = 1'b0;
      rx_ferr_ev    = 1'b0;
      if (rx_state != ULFC_IDLE) begin
         next_rx_cnt = (rx_cnt == divisor) ? 16'h0000 : 16'(rx_cnt + 16'h0001);
      end
      case (rx_state)
         ULFC_IDLE: begin
            if (!rx_sync) begin
               next_rx_fmt   = lfc;
               next_rx_data  = 8'h00;
               next_rx_perr  = 1'b0;
               next_rx_half  = 3'h0;
               next_rx_state = ULFC_START;
            end
         end
         ULFC_START: begin
            if (rx_cnt == divisor) begin
               next_rx_half  = 3'h0;
               next_rx_idx   = 3'h0;
               next_rx_state = rx_sync ? ULFC_IDLE : ULFC_DATA;
            end
         end
         ULFC_DATA: begin
            if (rx_cnt == divisor) begin
               next_rx_half = 3'(rx_half + 3'h1);
               if (rx_half == `ULFC_HALF_LAST) begin
                  next_rx_half         = 3'h0;
                  next_rx_data[rx_idx] = rx_sync;
                  next_rx_idx          = 3'(rx_idx + 3'h1);
                  if (rx_idx == last_bit(rx_fmt)) begin
                     next_rx_state = rx_fmt.par_en ? ULFC_PARITY : ULFC_STOP;
                  end
               end
            end
         end
         ULFC_PARITY: begin
            if (rx_cnt == divisor) begin
               next_rx_half = 3'(rx_half + 3'h1);
               if (rx_half == `ULFC_HALF_LAST) begin
                  next_rx_half  = 3'h0;
                  next_rx_perr  = (rx_sync != parity_of(rx_data, rx_fmt));
                  next_rx_state = ULFC_STOP;
               end
            end
         end
         ULFC_STOP: begin
            if (rx_cnt == divisor) begin
               next_rx_half = 3'(rx_half + 3'h1);
               if (rx_half == `ULFC_HALF_LAST) begin
                  rx_done_ev    = 1'b1;
                  rx_perr_ev    = rx_perr;
                  rx_ferr_ev    = !rx_sync;
                  next_rx_state = ULFC_IDLE;
               end
            end
         end
         default: next_rx_state = ULFC_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= ULFC_IDLE;
         rx_fmt   <= ulfc_format_t'(`ULFC_LFC_RESET);
         rx_cnt   <= 16'h0000;
         rx_half  <= 3'h0;
         rx_idx   <= 3'h0;
         rx_data  <= 8'h00;
         rx_perr  <= 1'b0;
      end else if (ce) begin
         rx_state <= next_rx_state;
         rx_fmt   <= next_rx_fmt;
         rx_cnt   <= next_rx_cnt;
         rx_half  <= next_rx_half;
         rx_idx   <= next_rx_idx;
         rx_data  <= next_rx_data;
         rx_perr  <= next_rx_perr;
      end
   end

endmodule

// ==== test/ulfc_line_format_props.sv ====
// Purpose: Port-level checks of the line format block.
// Assumes: Shadows of format, divisor, enhanced and mask track APB writes.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ps
`include "ulfc_defines.svh"
module ulfc_line_format_props
   import ulfc_pkg::*;
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    ce,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [`ULFC_ADDR_W-1:0] paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic                    rx_in,
   input wire logic                    tx_out,
   input wire logic                    irq
);
   logic [7:0]  fmt_sh, next_fmt_sh, efr_sh, next_efr_sh;
   logic [15:0] div_sh, next_div_sh;
   logic [3:0]  imr_sh, next_imr_sh;
   logic        wr_go, rd_go;
   assign wr_go = ce && psel && penable && pwrite && pready;
   assign rd_go = ce && psel && penable && !pwrite;
   always_comb begin
      next_fmt_sh = fmt_sh;
      next_div_sh = div_sh;
      next_efr_sh = efr_sh;
      next_imr_sh = imr_sh;
      if (wr_go && paddr == `ULFC_OFF_LFC) next_fmt_sh = pwdata[7:0];
      if (wr_go && fmt_sh[7] && paddr == `ULFC_OFF_DATA) next_div_sh = pwdata[15:0];
      if (wr_go && fmt_sh[7] && paddr == `ULFC_OFF_STAT) next_efr_sh = pwdata[7:0];
      if (wr_go && paddr == `ULFC_OFF_IMR) next_imr_sh = pwdata[3:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_sh <= `ULFC_LFC_RESET;
         div_sh <= `ULFC_DIV_RESET;
         efr_sh <= `ULFC_EFR_RESET;
         imr_sh <= 4'h0;
      end else begin
         fmt_sh <= next_fmt_sh;
         div_sh <= next_div_sh;
         efr_sh <= next_efr_sh;
         imr_sh <= next_imr_sh;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_zero_wait_a: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   slverr_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   unmapped_err_a: assert property (psel && penable && paddr > `ULFC_OFF_IMR |-> pslverr)
      else $error("no error on unmapped address");
   mapped_ok_a: assert property (psel && penable && paddr[1:0] == 2'h0
      && paddr <= `ULFC_OFF_IMR |-> !pslverr) else $error("error on mapped address");
   fmt_read_a: assert property (
      rd_go && paddr == `ULFC_OFF_LFC |-> prdata == {24'h0, fmt_sh})
      else $error("format register read wrong");
   brk_low_a: assert property (fmt_sh[6] |-> !tx_out)
      else $error("serial output high during break");
   div_read_a: assert property (
      rd_go && fmt_sh[7] && paddr == `ULFC_OFF_DATA |-> prdata == {16'h0, div_sh})
      else $error("divisor read wrong");
   efr_read_a: assert property (
      rd_go && fmt_sh[7] && paddr == `ULFC_OFF_STAT |-> prdata == {24'h0, efr_sh})
      else $error("enhanced register read wrong");
   irq_mask_a: assert property (imr_sh == 4'h0 |-> !irq)
      else $error("interrupt with all sources masked");
endmodule

bind ulfc_line_format ulfc_line_format_props u_props (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .irq(irq)
);

// ==== test/ulfc_serial_partner.sv ====
// Purpose: Remote serial partner that sends and samples characters.
// Assumes: HB pclk cycles per half bit, matching the divisor the bench sets.
// Notes:   The line idles high between frames.
`timescale 1ns/1ps
module ulfc_serial_partner #(
   parameter int HB = 8
) (
   input  wire logic pclk,
   input  wire logic tx_line,
   output logic      rx_line
);
   initial rx_line = 1'b1;
   task automatic send(input logic [7:0] d, input int n, input logic pe, pb, input int sh);
      int k;
      @(posedge pclk);
      rx_line <= 1'b0;
      repeat (2 * HB) @(posedge pclk);
      for (k = 0; k < n; k++) begin
         rx_line <= d[k];
         repeat (2 * HB) @(posedge pclk);
      end
      if (pe) begin
         rx_line <= pb;
         repeat (2 * HB) @(posedge pclk);
      end
      rx_line <= 1'b1;
      repeat (sh * HB) @(posedge pclk);
   endtask
   // Samples n bits after the start bit at mid bit; a lost start leaves garbage.
   task automatic recv(input int n, output logic [11:0] bits);
      int k;
      bits = 12'h0;
      k = 0;
      while (tx_line !== 1'b0 && k < 20000) begin
         @(posedge pclk);
         k++;
      end
      repeat (HB) @(posedge pclk);
      for (k = 0; k < n; k++) begin
         repeat (2 * HB) @(posedge pclk);
         bits[k] = tx_line;
      end
   endtask
endmodule

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the line format block.
// Assumes: Divisor set to HB-1 so a half bit lasts HB cycles.
// Notes:   Stop length is judged from the stop bit sample point to the tx_done interrupt.
`timescale 1ns/1ps
`include "ulfc_defines.svh"
module tb_top;
   localparam int HB = 8;
   logic        pclk, presetn, ce, psel, penable, pwrite, rx_in;
   logic        pready, pslverr, tx_out, irq, errv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   int          miscompares = 0;
   int          cmp_count = 0;
   logic [23:0] txv [10] = '{24'h0000B5, 24'h0404B5, 24'h0707B5, 24'h0B0BB5, 24'h1A1A31,
                             24'h29293F, 24'h39393F, 24'h31312A, 24'h0308C3, 24'h060615};
   logic [23:0] rxv [5] = '{24'h1B3C02, 24'h1B3C16, 24'h081516, 24'h00F502, 24'h2B8116};
   ulfc_line_format u_ulfc_line_format (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .irq(irq)
   );
   ulfc_serial_partner #(.HB(HB)) u_ulfc_serial_partner (
      .pclk(pclk), .tx_line(tx_out), .rx_line(rx_in)
   );
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;
   task automatic check(input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rdv, e);
   endtask
   function automatic logic par_of(input logic [7:0] f, d);
      logic [7:0] m;
      m = d & (8'hFF >> (2'h3 - f[1:0]));
      return f[5] ? ~f[4] : (f[4] ? ^m : ~^m);
   endfunction
   function automatic int sh_of(input logic [7:0] f);
      return !f[2] ? 2 : (f[1:0] == 2'h0 ? 3 : 4);
   endfunction
   task automatic tx_case(input logic [23:0] v);
      logic [11:0] bits, ex;
      int          i, m, w;
      m = 5 + v[17:16] + v[19];
      ex = 12'h0;
      for (i = 0; i < 5 + v[17:16]; i++) ex[i] = v[i];
      if (v[19]) ex[m-1] = par_of(v[23:16], v[7:0]);
      ex[m] = 1'b1;
      wr(`ULFC_OFF_LFC, {24'h0, v[23:16]});
      wr(`ULFC_OFF_IMR, 32'h1);
      apb(1'b0, `ULFC_OFF_ISR, 32'h0);
      fork
         u_ulfc_serial_partner.recv(m + 1, bits);
         begin
            wr(`ULFC_OFF_DATA, {24'h0, v[7:0]});
            wr(`ULFC_OFF_LFC, {24'h0, v[15:8]});
         end
      join
      w = 0;
      while (irq !== 1'b1 && w < 200) begin
         @(posedge pclk);
         w++;
      end
      check({20'h0, bits}, {20'h0, ex});
      check((w + HB / 2) / HB, sh_of(v[23:16]) - 1);
   endtask
   task automatic rx_case(input logic [23:0] v);
      wr(`ULFC_OFF_LFC, {24'h0, v[23:16]});
      wr(`ULFC_OFF_IMR, 32'h6);
      apb(1'b0, `ULFC_OFF_ISR, 32'h0);
      u_ulfc_serial_partner.send(v[15:8], 5 + v[17:16], v[19],
                                 par_of(v[23:16], v[15:8]) ^ v[4], sh_of(v[23:16]));
      check({31'h0, irq}, 32'h1);
      rd_chk(`ULFC_OFF_ISR, {28'h0, v[3:0]});
      @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      rd_chk(`ULFC_OFF_DATA, {24'h0, v[15:8] & (8'hFF >> (2'h3 - v[17:16]))});
   endtask
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`ULFC_OFF_LFC, 32'h0);
      wr(`ULFC_OFF_LFC, 32'h80);
      rd_chk(`ULFC_OFF_DATA, {16'h0, `ULFC_DIV_RESET});
      wr(`ULFC_OFF_DATA, 32'(HB - 1));
      rd_chk(`ULFC_OFF_DATA, 32'(HB - 1));
      wr(`ULFC_OFF_STAT, 32'hA5);
      rd_chk(`ULFC_OFF_STAT, 32'hA5);
      wr(`ULFC_OFF_LFC, 32'h0);
      rd_chk(`ULFC_OFF_STAT, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check({31'h0, errv}, 32'h1);
      check(rdv, 32'h0);
      wr(`ULFC_OFF_LFC, 32'h40);
      repeat (20) @(posedge pclk);
      check({31'h0, tx_out}, 32'h0);
      wr(`ULFC_OFF_LFC, 32'h0);
      @(posedge pclk);
      check({31'h0, tx_out}, 32'h1);
      foreach (txv[i]) tx_case(txv[i]);
      wr(`ULFC_OFF_IMR, 32'h0);
      @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      foreach (rxv[i]) rx_case(rxv[i]);
      give_verdict();
   end
endmodule
